// ### slu_pkg.sv
`default_nettype none
package slu_pkg;
	// Register select codes on the four address lines (hex)
	localparam logic [3:0] ADDR_IN_DATA   = 4'h8;
	localparam logic [3:0] ADDR_RX_CTRL   = 4'hA;
	localparam logic [3:0] ADDR_LINE_SIG  = 4'hB;
	localparam logic [3:0] ADDR_SYNC      = 4'hC;
	localparam logic [3:0] ADDR_SWITCH_A  = 4'hD;
	localparam logic [3:0] ADDR_SWITCH_B  = 4'hE;
	localparam logic [3:0] ADDR_MAINT     = 4'hF;

	// Receive control fields
	localparam int RXC_STAT_LSB      = 0;
	localparam int RXC_STAT_W        = 4;
	localparam int RXC_READY_BIT     = 4;
	localparam int RXC_LOOP_BIT      = 5;
	localparam int RXC_ACTIVE_BIT    = 6;
	localparam int RXC_CLEAR_BIT     = 7;

	// Line signal control fields
	localparam int LSC_SWA_BIT       = 0;
	localparam int LSC_SWB_BIT       = 1;
	localparam int LSC_CTS_BIT       = 2;
	localparam int LSC_MRDY_BIT      = 3;
	localparam int LSC_HDX_BIT       = 4;
	localparam int LSC_RTS_BIT       = 5;
	localparam int LSC_DTR_BIT       = 6;
	localparam int LSC_RING_BIT      = 7;

	// Maintenance fields
	localparam int MNT_MODE_BIT      = 0;
	localparam int MNT_OSC_BIT       = 1;
	localparam int MNT_RXACC_BIT     = 3;
	localparam int MNT_TXRDY_BIT     = 4;
	localparam int MNT_SIN_BIT       = 5;
	localparam int MNT_RXCRC_BIT     = 6;
	localparam int MNT_TXCRC_BIT     = 7;

	// Reset values
	localparam logic [7:0] SYNC_RESET    = 8'h00;
	localparam logic       HDX_RESET     = 1'b0;
	localparam logic       DTR_RESET     = 1'b1;
	localparam logic       MODE_RESET    = 1'b1;
	localparam logic       LOOP_RESET    = 1'b0;
	localparam logic [3:0] RXSTAT_RESET  = 4'h0;
endpackage
`default_nettype wire

// ### slu_sync2.sv
`default_nettype none
module slu_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Data
	input  wire logic [WIDTH-1:0] din,
	output var  logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	// Refused at elaboration, not at run time
	if (WIDTH < 1) begin : g_width_check
		$error("slu_sync2: WIDTH must be at least 1");
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
		end
	end

	assign dout = stage2;
endmodule
`default_nettype wire

// ### slu_rd_mux.sv
`default_nettype none
module slu_rd_mux (
	// Select
	input  wire logic [3:0] addr,
	// Sources
	input  wire logic [7:0] rx_ctrl,
	input  wire logic [7:0] line_sig,
	input  wire logic [7:0] sync_char,
	input  wire logic [7:0] sw_a,
	input  wire logic [7:0] sw_b,
	input  wire logic [7:0] maint,
	// Result
	output logic            hit,
	output logic [7:0]      data
);
	always_comb begin
		hit  = 1'b1;
		data = 8'h00;
		case (addr)
			slu_pkg::ADDR_RX_CTRL:  data = rx_ctrl;
			slu_pkg::ADDR_LINE_SIG: data = line_sig;
			slu_pkg::ADDR_SYNC:     data = sync_char;
			slu_pkg::ADDR_SWITCH_A: data = sw_a;
			slu_pkg::ADDR_SWITCH_B: data = sw_b;
			slu_pkg::ADDR_MAINT:    data = maint;
			default:                hit  = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ### slu_status_regs.sv
`default_nettype none
module slu_status_regs (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Microprocessor side
	input  wire logic       mp_clear,
	input  wire logic [3:0] mp_addr,
	input  wire logic       mp_rd,
	input  wire logic       mp_wr,
	input  wire logic [7:0] mp_wdata,
	output logic [7:0]      mp_rdata,
	output logic            mp_rhit,
	// Receive FIFO and receiver
	input  wire logic       rx_fifo_out_valid,
	input  wire logic [3:0] rx_fifo_out_stat,
	input  wire logic       rx_fifo_can_accept,
	input  wire logic       rx_data_start,
	input  wire logic       rx_sync_char,
	input  wire logic       rx_flag_char,
	input  wire logic       rx_crc_lsb,
	output logic            rx_clear_pulse,
	output logic            rx_clock_enable,
	output logic            rx_serial_in,
	// Transmitter
	input  wire logic       tx_fifo_out_ready,
	input  wire logic       tx_crc_lsb,
	input  wire logic       tx_serial_out,
	input  wire logic       tx_data_pending,
	output logic            tx_enable,
	output logic [7:0]      sync_char_station_addr,
	output logic            character_sync_mode,
	output logic            bit_stuff_mode,
	// Modem pins
	input  wire logic       modem_cts,
	input  wire logic       modem_ready,
	input  wire logic       modem_ring,
	input  wire logic       modem_rx_data,
	output logic            modem_tx_data,
	output logic            modem_rts,
	output logic            modem_dtr,
	// Switches and oscillator pins (switch closed reads low)
	input  wire logic       switch_flag_a_n,
	input  wire logic       switch_flag_b_n,
	input  wire logic [7:0] switch_bank_a,
	input  wire logic [7:0] switch_bank_b,
	input  wire logic       rc_osc
);
	typedef enum logic [1:0] {SLU_RX_IDLE, SLU_RX_HUNT, SLU_RX_DATA} slu_rx_state_type;

	// Synchronised pins
	// All pins cross in one bank; bits of one bank may still skew by a cycle
	localparam int PIN_W = 23;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s;
	logic       cts_s;
	logic       mrdy_s;
	logic       ring_s;
	logic       rxd_s;
	logic       swfa_s;
	logic       swfb_s;
	logic       osc_s;
	logic [7:0] swa_s;
	logic [7:0] swb_s;

	assign pin_raw = {switch_bank_b, switch_bank_a, rc_osc, switch_flag_b_n, switch_flag_a_n,
		modem_rx_data, modem_ring, modem_ready, modem_cts};

	slu_sync2 #(
		.WIDTH(PIN_W)
	) u_pin_sync (
		.clk (clk),
		.nrst(nrst),
		.din (pin_raw),
		.dout(pin_s)
	);

	assign cts_s  = pin_s[0];
	assign mrdy_s = pin_s[1];
	assign ring_s = pin_s[2];
	assign rxd_s  = pin_s[3];
	assign swfa_s = pin_s[4];
	assign swfb_s = pin_s[5];
	assign osc_s  = pin_s[6];
	assign swa_s  = pin_s[14:7];
	assign swb_s  = pin_s[22:15];

	// Register state
	logic [7:0]       sync_reg;
	logic [7:0]       next_sync_reg;
	logic             half_duplex_select;
	logic             next_half_duplex_select;
	logic             dtr;
	logic             next_dtr;
	logic             mode;
	logic             next_mode;
	logic             internal_loopback;
	logic             next_internal_loopback;
	logic [3:0]       rx_stat;
	logic [3:0]       next_rx_stat;
	logic             rts;
	logic             next_rts;
	logic             clr_pulse;
	logic             next_clr_pulse;
	slu_rx_state_type rx_state;
	slu_rx_state_type next_rx_state;

	logic wr_rxc;
	logic wr_lsc;
	logic wr_sync;
	logic wr_mnt;
	logic rd_data;
	logic rx_clear_now;

	assign wr_rxc  = mp_wr && (mp_addr == slu_pkg::ADDR_RX_CTRL);
	assign wr_lsc  = mp_wr && (mp_addr == slu_pkg::ADDR_LINE_SIG);
	assign wr_sync = mp_wr && (mp_addr == slu_pkg::ADDR_SYNC);
	assign wr_mnt  = mp_wr && (mp_addr == slu_pkg::ADDR_MAINT);
	assign rd_data = mp_rd && (mp_addr == slu_pkg::ADDR_IN_DATA);
	// Write-only clear bit, never stored
	assign rx_clear_now = (wr_rxc && mp_wdata[slu_pkg::RXC_CLEAR_BIT]) || mp_clear;

	// Programmable bits; only stored bits take writes, status positions ignore them
	always_comb begin
		next_sync_reg           = sync_reg;
		next_half_duplex_select = half_duplex_select;
		next_dtr                = dtr;
		next_mode               = mode;
		next_internal_loopback  = internal_loopback;
		if (wr_sync)
			next_sync_reg = mp_wdata;
		if (wr_lsc) begin
			next_half_duplex_select = mp_wdata[slu_pkg::LSC_HDX_BIT];
			next_dtr                = mp_wdata[slu_pkg::LSC_DTR_BIT];
		end
		if (wr_mnt)
			next_mode = mp_wdata[slu_pkg::MNT_MODE_BIT];
		if (wr_rxc)
			next_internal_loopback = mp_wdata[slu_pkg::RXC_LOOP_BIT];
		// Init overrides a write landing in the same cycle, except a write to the sync register
		if (mp_clear) begin
			next_half_duplex_select = slu_pkg::HDX_RESET;
			next_dtr                = slu_pkg::DTR_RESET;
			next_mode               = slu_pkg::MODE_RESET;
			next_internal_loopback  = slu_pkg::LOOP_RESET;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync_reg           <= slu_pkg::SYNC_RESET;
			half_duplex_select <= slu_pkg::HDX_RESET;
			dtr                <= slu_pkg::DTR_RESET;
			mode               <= slu_pkg::MODE_RESET;
			internal_loopback  <= slu_pkg::LOOP_RESET;
		end else begin
			sync_reg           <= next_sync_reg;
			half_duplex_select <= next_half_duplex_select;
			dtr                <= next_dtr;
			mode               <= next_mode;
			internal_loopback  <= next_internal_loopback;
		end
	end

	// Receiver status and entry into data reception
	always_comb begin
		next_rx_stat   = rx_stat;
		next_rx_state  = rx_state;
		next_clr_pulse = rx_clear_now;
		// Status is read after the data: the data read loads the status of the character it returns
		if (rd_data && rx_fifo_out_valid)
			next_rx_stat = rx_fifo_out_stat;
		// Sync and flag only qualify an assembled character
		case (rx_state)
			SLU_RX_IDLE: begin
				if (rx_data_start && (mode ? rx_sync_char : rx_flag_char))
					next_rx_state = SLU_RX_HUNT;
				else if (rx_data_start && mode)
					next_rx_state = SLU_RX_DATA;
			end
			SLU_RX_HUNT: begin
				if (rx_data_start && (mode ? !rx_sync_char : !rx_flag_char))
					next_rx_state = SLU_RX_DATA;
			end
			SLU_RX_DATA: begin
				// A new flag in bit-stuff mode starts the next frame's hunt
				if (rx_data_start && !mode && rx_flag_char)
					next_rx_state = SLU_RX_HUNT;
			end
			default: next_rx_state = SLU_RX_IDLE;
		endcase
		if (rx_clear_now) begin
			next_rx_stat  = slu_pkg::RXSTAT_RESET;
			next_rx_state = SLU_RX_IDLE;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_stat   <= slu_pkg::RXSTAT_RESET;
			clr_pulse <= 1'b0;
			rx_state  <= SLU_RX_IDLE;
		end else begin
			rx_stat   <= next_rx_stat;
			clr_pulse <= next_clr_pulse;
			rx_state  <= next_rx_state;
		end
	end

	// Request-to-send follows pending data, dropped by init
	always_comb begin
		next_rts = tx_data_pending && !mp_clear;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rts <= 1'b0;
		end else begin
			rts <= next_rts;
		end
	end

	// Outputs to the datapath
	assign rx_clear_pulse         = clr_pulse;
	assign sync_char_station_addr = sync_reg;
	assign character_sync_mode    = mode;
	assign bit_stuff_mode         = !mode;
	assign modem_dtr              = dtr;
	assign modem_rts              = internal_loopback ? 1'b0 : rts;
	// Loopback isolates modem lines from the receiver
	assign rx_serial_in   = internal_loopback ? tx_serial_out : rxd_s;
	assign modem_tx_data  = internal_loopback ? 1'b1 : tx_serial_out;
	// Loopback does not fake the modem handshake
	assign tx_enable      = cts_s && mrdy_s;
	// Half duplex blinds receiver while sending
	assign rx_clock_enable = !(half_duplex_select && rts);

	// Read images assembled from live sources
	logic [7:0] rxc_img;
	logic [7:0] lsc_img;
	logic [7:0] mnt_img;

	always_comb begin
		rxc_img = 8'h00;
		rxc_img[slu_pkg::RXC_STAT_LSB +: slu_pkg::RXC_STAT_W] = rx_stat;
		rxc_img[slu_pkg::RXC_READY_BIT]  = rx_fifo_out_valid;
		rxc_img[slu_pkg::RXC_LOOP_BIT]   = internal_loopback;
		rxc_img[slu_pkg::RXC_ACTIVE_BIT] = (rx_state == SLU_RX_DATA);
		lsc_img = 8'h00;
		lsc_img[slu_pkg::LSC_SWA_BIT]  = swfa_s;
		lsc_img[slu_pkg::LSC_SWB_BIT]  = swfb_s;
		lsc_img[slu_pkg::LSC_CTS_BIT]  = cts_s;
		lsc_img[slu_pkg::LSC_MRDY_BIT] = mrdy_s;
		lsc_img[slu_pkg::LSC_HDX_BIT]  = half_duplex_select;
		lsc_img[slu_pkg::LSC_RTS_BIT]  = rts;
		lsc_img[slu_pkg::LSC_DTR_BIT]  = dtr;
		lsc_img[slu_pkg::LSC_RING_BIT] = ring_s;
		mnt_img = 8'h00;
		mnt_img[slu_pkg::MNT_MODE_BIT]  = mode;
		mnt_img[slu_pkg::MNT_OSC_BIT]   = osc_s;
		mnt_img[slu_pkg::MNT_RXACC_BIT] = rx_fifo_can_accept;
		mnt_img[slu_pkg::MNT_TXRDY_BIT] = tx_fifo_out_ready;
		mnt_img[slu_pkg::MNT_SIN_BIT]   = rxd_s;
		mnt_img[slu_pkg::MNT_RXCRC_BIT] = rx_crc_lsb;
		mnt_img[slu_pkg::MNT_TXCRC_BIT] = tx_crc_lsb;
	end

	// Combinational read so status is current at the read
	slu_rd_mux u_rd_mux (
		.addr     (mp_addr),
		.rx_ctrl  (rxc_img),
		.line_sig (lsc_img),
		.sync_char(sync_reg),
		.sw_a     (swa_s),
		.sw_b     (swb_s),
		.maint    (mnt_img),
		.hit      (mp_rhit),
		.data     (mp_rdata)
	);
endmodule
`default_nettype wire

// ### slu_status_regs_checker.sv
`default_nettype none
module slu_status_regs_checker (
	// Clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// Microprocessor side
	input wire logic       mp_clear,
	input wire logic [3:0] mp_addr,
	input wire logic       mp_wr,
	input wire logic [7:0] mp_wdata,
	input wire logic [7:0] mp_rdata,
	input wire logic       mp_rhit,
	// Live status and datapath
	input wire logic       rx_fifo_out_valid,
	input wire logic       rx_fifo_can_accept,
	input wire logic       tx_fifo_out_ready,
	input wire logic       rx_crc_lsb,
	input wire logic       tx_crc_lsb,
	input wire logic       rx_clear_pulse,
	input wire logic       rx_clock_enable,
	input wire logic       rx_serial_in,
	input wire logic       tx_serial_out,
	input wire logic [7:0] sync_char_station_addr,
	input wire logic       character_sync_mode,
	input wire logic       bit_stuff_mode,
	input wire logic       modem_tx_data,
	input wire logic       modem_rts,
	input wire logic       modem_dtr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic clr_cause;
	sequence s_clear_wr;
		mp_wr && mp_addr == slu_pkg::ADDR_RX_CTRL && mp_wdata[7];
	endsequence
	sequence s_init;
		mp_clear ##0 !mp_wr;
	endsequence
	// Remembers why a clear pulse may appear one cycle later
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clr_cause <= 1'b0;
		end else begin
			clr_cause <= mp_clear || (mp_wr && mp_addr == slu_pkg::ADDR_RX_CTRL && mp_wdata[7]);
		end
	end
	AST_RX_READY: assert property (mp_addr == slu_pkg::ADDR_RX_CTRL |-> mp_rdata[4] == rx_fifo_out_valid)
		else $error("receive ready bit differs from fifo valid");
	AST_RX_CLEAR: assert property (s_clear_wr |=> rx_clear_pulse)
		else $error("receiver clear pulse missing");
	AST_PULSE_CAUSE: assert property (rx_clear_pulse |-> clr_cause)
		else $error("receiver clear pulse without cause");
	AST_INIT: assert property (s_init |=>
		modem_dtr && character_sync_mode && !modem_rts && rx_clear_pulse)
		else $error("clear signal did not initialise");
	AST_MODE_PAIR: assert property (mp_addr == slu_pkg::ADDR_MAINT |->
		mp_rdata[0] == character_sync_mode && bit_stuff_mode != character_sync_mode)
		else $error("mode bit and mode outputs disagree");
	AST_MAINT_LIVE: assert property (mp_addr == slu_pkg::ADDR_MAINT |->
		mp_rdata[7:2] == {tx_crc_lsb, rx_crc_lsb, mp_rdata[5], tx_fifo_out_ready, rx_fifo_can_accept, 1'b0})
		else $error("maintenance status bits not live");
	AST_HDX_GATE: assert property (mp_addr == slu_pkg::ADDR_LINE_SIG |->
		rx_clock_enable == !(mp_rdata[4] && mp_rdata[5]))
		else $error("receiver clock gate wrong");
	AST_DTR: assert property (mp_addr == slu_pkg::ADDR_LINE_SIG |-> mp_rdata[6] == modem_dtr)
		else $error("terminal ready bit differs from pin");
	AST_LOOP: assert property (mp_addr == slu_pkg::ADDR_RX_CTRL && mp_rdata[5] |->
		modem_tx_data && !modem_rts && rx_serial_in == tx_serial_out)
		else $error("loopback routing wrong");
	AST_SYNC_WR: assert property (mp_wr && mp_addr == slu_pkg::ADDR_SYNC |=>
		sync_char_station_addr == $past(mp_wdata))
		else $error("sync register write lost");
	AST_SYNC_HOLD: assert property (!(mp_wr && mp_addr == slu_pkg::ADDR_SYNC) |=>
		$stable(sync_char_station_addr))
		else $error("sync register changed without write");
	AST_DECODE: assert property (mp_rhit == (mp_addr >= slu_pkg::ADDR_RX_CTRL) && (mp_rhit || mp_rdata == 8'h00))
		else $error("register decode wrong");
endmodule
bind slu_status_regs slu_status_regs_checker u_chk (.clk, .nrst, .mp_clear, .mp_addr, .mp_wr, .mp_wdata, .mp_rdata,
	.mp_rhit, .rx_fifo_out_valid, .rx_fifo_can_accept, .tx_fifo_out_ready, .rx_crc_lsb, .tx_crc_lsb, .rx_clear_pulse,
	.rx_clock_enable, .rx_serial_in, .tx_serial_out, .sync_char_station_addr, .character_sync_mode, .bit_stuff_mode,
	.modem_tx_data, .modem_rts, .modem_dtr);
`default_nettype wire

// ### slu_mp_model.sv
`default_nettype none
module slu_mp_model (
	// Clock
	input  wire logic       clk,
	// Register bus
	input  wire logic [7:0] mp_rdata,
	input  wire logic       mp_rhit,
	output logic            mp_clear,
	output logic [3:0]      mp_addr,
	output logic            mp_rd,
	output logic            mp_wr,
	output logic [7:0]      mp_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{mp_clear, mp_addr, mp_rd, mp_wr, mp_wdata} = '0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		mp_addr = a;
		mp_wdata = d;
		mp_wr = 1'b1;
		@(posedge clk);
		#1;
		mp_wr = 1'b0;
		// Stale data must not look valid
		mp_wdata = ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic h);
		@(posedge clk);
		#1;
		mp_addr = a;
		#2;
		d = mp_rdata;
		h = mp_rhit;
	endtask
	// One-cycle strobe: data register read, or clear when clr is set
	task automatic strobe(input logic clr);
		@(posedge clk);
		#1;
		mp_addr = slu_pkg::ADDR_IN_DATA;
		mp_clear = clr;
		mp_rd = !clr;
		@(posedge clk);
		#1;
		mp_clear = 1'b0;
		mp_rd = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mp_rdata, mp_wdata, sync_char_station_addr, switch_bank_a, switch_bank_b;
	logic [3:0] mp_addr, rx_fifo_out_stat;
	logic       clk, nrst, mp_clear, mp_rd, mp_wr, mp_rhit, rx_fifo_out_valid, rx_fifo_can_accept, rx_data_start;
	logic       rx_sync_char, rx_flag_char, rx_crc_lsb, rx_clear_pulse, rx_clock_enable, rx_serial_in;
	logic       tx_fifo_out_ready, tx_crc_lsb, tx_serial_out, tx_data_pending, tx_enable, character_sync_mode;
	logic       bit_stuff_mode, modem_cts, modem_ready, modem_ring, modem_rx_data, modem_tx_data, modem_rts;
	logic       modem_dtr, switch_flag_a_n, switch_flag_b_n, rc_osc;
	int         miscompares = 0;
	int         total_checks = 0;

	slu_status_regs uut (.clk, .nrst, .mp_clear, .mp_addr, .mp_rd, .mp_wr, .mp_wdata, .mp_rdata, .mp_rhit,
		.rx_fifo_out_valid, .rx_fifo_out_stat, .rx_fifo_can_accept, .rx_data_start, .rx_sync_char, .rx_flag_char,
		.rx_crc_lsb, .rx_clear_pulse, .rx_clock_enable, .rx_serial_in, .tx_fifo_out_ready, .tx_crc_lsb,
		.tx_serial_out, .tx_data_pending, .tx_enable, .sync_char_station_addr, .character_sync_mode,
		.bit_stuff_mode, .modem_cts, .modem_ready, .modem_ring, .modem_rx_data, .modem_tx_data, .modem_rts,
		.modem_dtr, .switch_flag_a_n, .switch_flag_b_n, .switch_bank_a, .switch_bank_b, .rc_osc);
	slu_mp_model mp (.clk, .mp_rdata, .mp_rhit, .mp_clear, .mp_addr, .mp_rd, .mp_wr, .mp_wdata);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       h;
		mp.rd(a, d, h);
		chk(d, exp);
		chk({7'h00, h}, {7'h00, a >= slu_pkg::ADDR_RX_CTRL});
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	// Pin pattern; results show after the two-flop synchronisers
	task automatic pat(input logic [10:0] v);
		@(posedge clk);
		#1;
		{tx_crc_lsb, rx_crc_lsb, modem_rx_data, tx_fifo_out_ready, rx_fifo_can_accept, rc_osc, modem_ring,
			modem_ready, modem_cts, switch_flag_b_n, switch_flag_a_n} = v;
		repeat (3) @(posedge clk);
		rchk(slu_pkg::ADDR_LINE_SIG, {v[4], 3'b100, v[3:0]});
		rchk(slu_pkg::ADDR_MAINT, {v[10:6], 1'b0, v[5], 1'b1});
		chk({7'h00, tx_enable}, {7'h00, v[2] & v[3]});
	endtask
	task automatic rx_char(input logic s, input logic f);
		@(posedge clk);
		#1;
		{rx_data_start, rx_sync_char, rx_flag_char} = {1'b1, s, f};
		@(posedge clk);
		#1;
		rx_data_start = 1'b0;
	endtask

	initial begin
		{nrst, rx_fifo_out_valid, rx_fifo_out_stat, rx_fifo_can_accept, rx_data_start, rx_sync_char} = '0;
		{rx_flag_char, rx_crc_lsb, tx_fifo_out_ready, tx_crc_lsb, tx_serial_out, tx_data_pending} = '0;
		{modem_cts, modem_ready, modem_ring, modem_rx_data, switch_flag_a_n, switch_flag_b_n, rc_osc} = '0;
		{switch_bank_a, switch_bank_b} = {8'h3C, 8'hC3};
		repeat (6) @(posedge clk);
		#1;
		nrst = 1'b1;
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h00);
		rchk(slu_pkg::ADDR_LINE_SIG, 8'h40);
		rchk(slu_pkg::ADDR_MAINT, 8'h01);
		rchk(4'h9, 8'h00);
		mp.wr(slu_pkg::ADDR_SYNC, 8'h5A);
		mp.wr(slu_pkg::ADDR_SYNC, 8'hA5);
		rchk(slu_pkg::ADDR_SYNC, 8'hA5);
		mp.wr(slu_pkg::ADDR_SWITCH_A, 8'h00);
		mp.wr(slu_pkg::ADDR_SWITCH_B, 8'hFF);
		rchk(slu_pkg::ADDR_SWITCH_A, 8'h3C);
		rchk(slu_pkg::ADDR_SWITCH_B, 8'hC3);
		pat(11'h5AD);
		pat(11'h252);
		step();
		{rx_fifo_out_valid, rx_fifo_out_stat} = 5'h1B;
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h10);
		mp.strobe(1'b0);
		rx_fifo_out_valid = 1'b0;
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h0B);
		rx_char(1'b1, 1'b0);
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h0B);
		rx_char(1'b0, 1'b0);
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h4B);
		mp.wr(slu_pkg::ADDR_RX_CTRL, 8'h80);
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h00);
		mp.wr(slu_pkg::ADDR_MAINT, 8'h00);
		rchk(slu_pkg::ADDR_MAINT, 8'h48);
		rx_char(1'b0, 1'b0);
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h00);
		rx_char(1'b0, 1'b1);
		rx_char(1'b0, 1'b0);
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h40);
		mp.strobe(1'b1);
		rchk(slu_pkg::ADDR_MAINT, 8'h49);
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h00);
		mp.wr(slu_pkg::ADDR_LINE_SIG, 8'hFF);
		rchk(slu_pkg::ADDR_LINE_SIG, 8'hD2);
		step();
		tx_data_pending = 1'b1;
		rchk(slu_pkg::ADDR_LINE_SIG, 8'hF2);
		chk({7'h00, modem_rts}, 8'h01);
		chk({7'h00, rx_clock_enable}, 8'h00);
		step();
		tx_data_pending = 1'b0;
		rchk(slu_pkg::ADDR_LINE_SIG, 8'hD2);
		chk({7'h00, rx_clock_enable}, 8'h01);
		mp.strobe(1'b1);
		rchk(slu_pkg::ADDR_LINE_SIG, 8'hC2);
		mp.wr(slu_pkg::ADDR_LINE_SIG, 8'h00);
		rchk(slu_pkg::ADDR_LINE_SIG, 8'h82);
		mp.strobe(1'b1);
		chk({7'h00, modem_dtr}, 8'h01);
		mp.wr(slu_pkg::ADDR_RX_CTRL, 8'h20);
		rchk(slu_pkg::ADDR_RX_CTRL, 8'h20);
		step();
		tx_data_pending = 1'b1;
		step();
		chk({5'h00, modem_rts, rx_serial_in, modem_tx_data}, 8'h01);
		tx_serial_out = 1'b1;
		#1;
		chk({5'h00, modem_rts, rx_serial_in, modem_tx_data}, 8'h03);
		mp.wr(slu_pkg::ADDR_RX_CTRL, 8'h00);
		chk({7'h00, modem_rts}, 8'h01);
		wrap_up();
	end
	// Whole sequence needs under a hundred cycles
	initial begin
		#100us;
		miscompares++;
		wrap_up();
	end
endmodule
`default_nettype wire
